// ---- common/scc_defines.vh ----
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SCC_REG_CTRL       4'h0
`define SCC_REG_LIVE_BUS   4'h1
`define SCC_REG_DEAD_BUS   4'h2
`define SCC_REG_LIVE_LINE  4'h3
`define SCC_REG_DEAD_LINE  4'h4
`define SCC_REG_MAX_VOLT   4'h5
`define SCC_REG_MAX_ANGLE  4'h6
`define SCC_REG_MAX_SLIP   4'h7
`define SCC_REG_MAKE_DELAY 4'h8
`define SCC_REG_STATUS     4'h9
// ----------------------------------------------------------------
// ctrl fields
// ----------------------------------------------------------------
`define SCC_CTRL_EN        0
`define SCC_CTRL_DS_LO     1
`define SCC_CTRL_DS_HI     3
`define SCC_CTRL_BYP_LO    4
`define SCC_CTRL_BYP_HI    10
// ----------------------------------------------------------------
// reset values (levels in 0.01 x VT, volts, degrees, 10 mHz, 10 ms)
// ----------------------------------------------------------------
`define SCC_RST_CTRL       16'h0000
`define SCC_RST_LIVE       16'h0032
`define SCC_RST_DEAD       16'h000a
`define SCC_RST_MAX_VOLT   16'h03e8
`define SCC_RST_MAX_ANGLE  16'h000a
`define SCC_RST_MAX_SLIP   16'h0005
`define SCC_RST_MAKE_DELAY 16'h000a
// ----------------------------------------------------------------
// slip bands in mHz and timing
// ----------------------------------------------------------------
`define SCC_SLIP_LOW_MHZ   16'h0014
`define SCC_SLIP_HIGH_MHZ  16'h001e
`define SCC_MHZ_PER_LSB    16'h000a
`define SCC_CLK_HZ         50000000
`define SCC_PASS_HZ        240
`define SCC_MS_PER_LSB     10
// ----------------------------------------------------------------
// dead-source choices
// ----------------------------------------------------------------
`define SCC_DS_NONE        3'h0
`define SCC_DS_BOTH_DEAD_PERMIT       3'h1
`define SCC_DS_LIVE_LINE_DEAD_BUS_PERMIT       3'h2
`define SCC_DS_DEAD_LINE_LIVE_BUS_PERMIT       3'h3
`define SCC_DS_ANY_LINE_DEAD_BUS_PERMIT       3'h4
`define SCC_DS_DEAD_LINE_ANY_BUS_PERMIT       3'h5
`define SCC_DS_ONE_SIDE_DEAD_PERMIT       3'h6
`define SCC_DS_NBL         3'h7
// ----------------------------------------------------------------
// bypass selector codes
// ----------------------------------------------------------------
`define SCC_BYP_OFF        7'h00
`define SCC_BYP_ON         7'h01
`define SCC_BYP_CI_BASE    7'h02
`define SCC_BYP_VI_BASE    7'h0c
`define SCC_BYP_RI_BASE    7'h2c
`define SCC_BYP_LE_BASE    7'h4c
`define SCC_BYP_LE_END     7'h5c
`endif

// ---- rtl/scc_close_permit.v ----
`include "scc_defines.vh"
module scc_close_permit #(
  parameter CLK_HZ   = `SCC_CLK_HZ,
  parameter PASS_DIV = `SCC_CLK_HZ / `SCC_PASS_HZ,
  parameter W        = 16
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          rst,
  // register port
  input  wire [3:0]    reg_addr,
  input  wire [15:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [15:0]   reg_rdata,
  // measurements from front end, same clock
  input  wire [W-1:0]  line_side_voltage,
  input  wire [W-1:0]  bus_side_voltage,
  input  wire [W-1:0]  line_volts_abs,
  input  wire [W-1:0]  bus_volts_abs,
  input  wire [W-1:0]  angle_diff_deg,
  input  wire [W-1:0]  slip_mhz,
  input  wire          angle_closing,
  input  wire [W-1:0]  time_to_phase_ms,
  // operand sources, from pins
  input  wire [9:0]    contact_in,
  input  wire [31:0]   virtual_in,
  input  wire [31:0]   remote_in,
  input  wire [15:0]   logic_elem,
  input  wire          block_in,
  // close permission
  output reg           close_permit,
  output reg  [5:0]    output_relays
);

  function [0:0] at_or_above;
    input [W-1:0] v;
    input [15:0]  lvl;
    begin
      at_or_above = (v >= lvl);
    end
  endfunction

  function [0:0] at_or_below;
    input [W-1:0] v;
    input [15:0]  lvl;
    begin
      at_or_below = (v <= lvl);
    end
  endfunction

  // register index match, shared by every write strobe
  function [0:0] addr_hit;
    input [3:0] a;
    input [3:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pins are asynchronous; two flops bound metastability
  reg [90:0] sync1_q;
  reg [90:0] sync2_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= {91{1'b0}};
      sync2_q <= {91{1'b0}};
    end else begin
      sync1_q <= {block_in, logic_elem, remote_in, virtual_in, contact_in};
      sync2_q <= sync1_q;
    end
  end
  wire [89:0] operands = sync2_q[89:0];
  wire        block_s  = sync2_q[90];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] ctrl_q;
  reg [15:0] live_bus_q;
  reg [15:0] dead_bus_q;
  reg [15:0] live_line_q;
  reg [15:0] dead_line_q;
  reg [15:0] max_volt_q;
  reg [15:0] max_angle_q;
  reg [15:0] max_slip_limit_q;
  reg [15:0] breaker_make_delay_q;
  reg [15:0] status_q;

  // one strobe per register; unmapped and status writes hit none
  wire wr_ctrl       = reg_wr && addr_hit(reg_addr, `SCC_REG_CTRL);
  wire wr_live_bus   = reg_wr && addr_hit(reg_addr, `SCC_REG_LIVE_BUS);
  wire wr_dead_bus   = reg_wr && addr_hit(reg_addr, `SCC_REG_DEAD_BUS);
  wire wr_live_line  = reg_wr && addr_hit(reg_addr, `SCC_REG_LIVE_LINE);
  wire wr_dead_line  = reg_wr && addr_hit(reg_addr, `SCC_REG_DEAD_LINE);
  wire wr_max_volt   = reg_wr && addr_hit(reg_addr, `SCC_REG_MAX_VOLT);
  wire wr_max_angle  = reg_wr && addr_hit(reg_addr, `SCC_REG_MAX_ANGLE);
  wire wr_max_slip   = reg_wr && addr_hit(reg_addr, `SCC_REG_MAX_SLIP);
  wire wr_make_delay = reg_wr && addr_hit(reg_addr, `SCC_REG_MAKE_DELAY);

  always @(posedge ref_clk) begin
    if (rst)
      ctrl_q <= `SCC_RST_CTRL;
    else if (wr_ctrl)
      ctrl_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      live_bus_q <= `SCC_RST_LIVE;
    else if (wr_live_bus)
      live_bus_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      dead_bus_q <= `SCC_RST_DEAD;
    else if (wr_dead_bus)
      dead_bus_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      live_line_q <= `SCC_RST_LIVE;
    else if (wr_live_line)
      live_line_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      dead_line_q <= `SCC_RST_DEAD;
    else if (wr_dead_line)
      dead_line_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      max_volt_q <= `SCC_RST_MAX_VOLT;
    else if (wr_max_volt)
      max_volt_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      max_angle_q <= `SCC_RST_MAX_ANGLE;
    else if (wr_max_angle)
      max_angle_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      max_slip_limit_q <= `SCC_RST_MAX_SLIP;
    else if (wr_max_slip)
      max_slip_limit_q <= reg_wdata;
  end

  always @(posedge ref_clk) begin
    if (rst)
      breaker_make_delay_q <= `SCC_RST_MAKE_DELAY;
    else if (wr_make_delay)
      breaker_make_delay_q <= reg_wdata;
  end

  // read data is zero outside its answer cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SCC_REG_CTRL:       reg_rdata <= ctrl_q;
        `SCC_REG_LIVE_BUS:   reg_rdata <= live_bus_q;
        `SCC_REG_DEAD_BUS:   reg_rdata <= dead_bus_q;
        `SCC_REG_LIVE_LINE:  reg_rdata <= live_line_q;
        `SCC_REG_DEAD_LINE:  reg_rdata <= dead_line_q;
        `SCC_REG_MAX_VOLT:   reg_rdata <= max_volt_q;
        `SCC_REG_MAX_ANGLE:  reg_rdata <= max_angle_q;
        `SCC_REG_MAX_SLIP:   reg_rdata <= max_slip_limit_q;
        `SCC_REG_MAKE_DELAY: reg_rdata <= breaker_make_delay_q;
        `SCC_REG_STATUS:     reg_rdata <= status_q;
        default:             reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  wire       enable  = ctrl_q[`SCC_CTRL_EN];
  wire [2:0] dead_src = ctrl_q[`SCC_CTRL_DS_HI:`SCC_CTRL_DS_LO];
  wire [6:0] byp_sel  = ctrl_q[`SCC_CTRL_BYP_HI:`SCC_CTRL_BYP_LO];

  // ----------------------------------------------------------------
  // protection pass tick
  // ----------------------------------------------------------------
  // all decisions sample at one pass rate so settings act coherently
  reg [31:0] pass_cnt_q;
  wire       pass_tick = (pass_cnt_q == PASS_DIV - 1);
  always @(posedge ref_clk) begin
    if (rst || pass_tick)
      pass_cnt_q <= 32'h0;
    else
      pass_cnt_q <= pass_cnt_q + 32'h1;
  end

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  wire bus_live  = at_or_above(bus_side_voltage, live_bus_q);
  wire bus_dead  = at_or_below(bus_side_voltage, dead_bus_q);
  wire line_live = at_or_above(line_side_voltage, live_line_q);
  wire line_dead = at_or_below(line_side_voltage, dead_line_q);

  // ----------------------------------------------------------------
  // live line, live bus
  // ----------------------------------------------------------------
  wire [W-1:0] vdiff = (line_volts_abs > bus_volts_abs) ?
                       line_volts_abs - bus_volts_abs :
                       bus_volts_abs - line_volts_abs;
  wire volt_ok  = at_or_below(vdiff, max_volt_q);
  wire angle_ok = (angle_diff_deg < max_angle_q);
  wire [31:0] slip_lim_mhz = max_slip_limit_q * `SCC_MHZ_PER_LSB;
  wire slip_ok  = ({16'h0, slip_mhz} <= slip_lim_mhz);
  wire slow_slip = at_or_below(slip_mhz, `SCC_SLIP_LOW_MHZ);
  wire fast_slip = (slip_mhz > `SCC_SLIP_HIGH_MHZ);
  wire [31:0] make_ms = breaker_make_delay_q * `SCC_MS_PER_LSB;
  // limitation: time to coincidence comes ready-made from the front end
  // close order released once phase meets within breaker make time
  wire anticip_ok = angle_closing &&
                    ({16'h0, time_to_phase_ms} <= make_ms);
  // between 20 and 30 mHz keep the last band's method (hysteresis)
  reg  fast_mode_q;
  always @(posedge ref_clk) begin
    if (rst)
      fast_mode_q <= 1'b0;
    else if (pass_tick && fast_slip)
      fast_mode_q <= 1'b1;
    else if (pass_tick && slow_slip)
      fast_mode_q <= 1'b0;
  end
  wire phase_ok = fast_mode_q ? (anticip_ok && angle_ok)
                              : angle_ok;
  wire both_live = line_live && bus_live;
  wire sync_ok = both_live && volt_ok && slip_ok && phase_ok;

  // ----------------------------------------------------------------
  // dead source
  // ----------------------------------------------------------------
  reg dead_ok;
  always @* begin
    case (dead_src)
      `SCC_DS_BOTH_DEAD_PERMIT: dead_ok = line_dead && bus_dead;
      `SCC_DS_LIVE_LINE_DEAD_BUS_PERMIT: dead_ok = line_live && bus_dead;
      `SCC_DS_DEAD_LINE_LIVE_BUS_PERMIT: dead_ok = line_dead && bus_live;
      `SCC_DS_ANY_LINE_DEAD_BUS_PERMIT: dead_ok = bus_dead;
      `SCC_DS_DEAD_LINE_ANY_BUS_PERMIT: dead_ok = line_dead;
      `SCC_DS_ONE_SIDE_DEAD_PERMIT: dead_ok = line_live != bus_live;
      `SCC_DS_NBL:   dead_ok = !both_live;
      default:       dead_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // bypass
  // ----------------------------------------------------------------
  reg bypass;
  always @* begin
    if (byp_sel == `SCC_BYP_ON)
      bypass = 1'b1;
    else if (byp_sel >= `SCC_BYP_CI_BASE && byp_sel < `SCC_BYP_LE_END)
      bypass = operands[byp_sel - `SCC_BYP_CI_BASE];
    else
      bypass = 1'b0;
  end

  // ----------------------------------------------------------------
  // pass evaluation
  // ----------------------------------------------------------------
  wire permit_d = enable &&
                  (bypass || (!block_s && (sync_ok || dead_ok)));

  // status taken at the same tick as the permit it explains
  wire [15:0] status_d = {7'h00,
                          fast_mode_q,
                          bypass,
                          dead_ok,
                          sync_ok,
                          permit_d,
                          bus_dead,
                          bus_live,
                          line_dead,
                          line_live};

  // ----------------------------------------------------------------
  // pass outputs
  // ----------------------------------------------------------------
  // permit holds between ticks so a close order never chatters
  always @(posedge ref_clk) begin
    if (rst)
      close_permit <= 1'b0;
    else if (pass_tick)
      close_permit <= permit_d;
  end

  // all six relays follow the permit in the same cycle
  always @(posedge ref_clk) begin
    if (rst)
      output_relays <= 6'h00;
    else if (pass_tick)
      output_relays <= {6{permit_d}};
  end

  always @(posedge ref_clk) begin
    if (rst)
      status_q <= 16'h0000;
    else if (pass_tick)
      status_q <= status_d;
  end

endmodule // scc_close_permit

// ---- sim/scc_close_permit_asserts.sv ----
module scc_close_permit_asserts #(
  parameter PASS_DIV = 8
) (
  // clock, reset, register port
  input logic        ref_clk,
  input logic        rst,
  input logic [3:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  // block input and permission
  input logic        block_in,
  input logic        close_permit,
  input logic [5:0]  output_relays
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------
  // bypass tracking from writes seen on the port
  // ------------------------------------------------
  logic byp_off_q;
  always_ff @(posedge ref_clk) begin
    if (rst) byp_off_q <= 1'b1;
    else if (reg_wr && reg_addr == 4'h0) byp_off_q <= reg_wdata[10:4] == 7'h00;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RELAYS: assert property (output_relays == {6{close_permit}})
    else $error("relays differ from permit");
  AST_RST: assert property (disable iff (1'b0) rst |=> !close_permit
    && output_relays == 6'h00 && reg_rdata == 16'h0000)
    else $error("outputs not cleared by reset");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > 4'h9 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_PASS: assert property ($rose(close_permit) |=> $stable(close_permit)[*7])
    else $error("permit changed within a pass");
  AST_DIS: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[0] ##1
    !(reg_wr && reg_addr == 4'h0) [*8] |=> !close_permit)
    else $error("permit while disabled");
  AST_BLOCK: assert property ((block_in && byp_off_q) [*8] ##1
    (block_in && byp_off_q) [*4] |=> !close_permit)
    else $error("permit while blocked");
  AST_BYPASS: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[0] &&
    reg_wdata[10:4] == 7'h01 ##1 !(reg_wr && reg_addr == 4'h0) [*8] |=> close_permit)
    else $error("bypass on did not force permit");
endmodule // scc_close_permit_asserts
bind scc_close_permit scc_close_permit_asserts #(.PASS_DIV(PASS_DIV))
  i_scc_close_permit_asserts (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .block_in(block_in), .close_permit(close_permit), .output_relays(output_relays));

// ---- sim/scc_front_end_model.sv ----
module scc_front_end_model (
  // measurements toward the block
  output logic [15:0] line_side_voltage,
  output logic [15:0] bus_side_voltage,
  output logic [15:0] line_volts_abs,
  output logic [15:0] bus_volts_abs,
  output logic [15:0] angle_diff_deg,
  output logic [15:0] slip_mhz,
  output logic        angle_closing,
  output logic [15:0] time_to_phase_ms
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus magnitude fixed, line side carries the difference
  task automatic set(input logic [15:0] lv, bv, la, ang, slip,
                     input logic clo, input logic [15:0] ttp);
    line_side_voltage <= lv;
    bus_side_voltage  <= bv;
    line_volts_abs    <= la;
    bus_volts_abs     <= 16'h03e8;
    angle_diff_deg    <= ang;
    slip_mhz          <= slip;
    angle_closing     <= clo;
    time_to_phase_ms  <= ttp;
  endtask
  initial set(16'h0, 16'h0, 16'h3e8, 16'h0, 16'h0, 1'b0, 16'h0);
endmodule // scc_front_end_model

// ---- sim/scc_close_permit_bench.sv ----
`include "scc_defines.vh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  miscompares++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module scc_close_permit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] lv, bv; logic [15:0] la; logic [7:0] ang, slip;
    logic clo; logic [7:0] ttp, ctrl; logic ex;
  } scc_row_t;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, block_in = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, lsv, bsv, lva, bva, ang, slp, ttp;
  logic [9:0] contact_in = 10'h0;
  logic [31:0] virtual_in = 32'h0, remote_in = 32'h0;
  logic [15:0] logic_elem = 16'h0;
  logic clo, close_permit;
  logic [5:0] output_relays;
  int miscompares = 0, n_compared = 0;
  logic [15:0] dflt [9] = '{`SCC_RST_CTRL, `SCC_RST_LIVE, `SCC_RST_DEAD,
    `SCC_RST_LIVE, `SCC_RST_DEAD, `SCC_RST_MAX_VOLT, `SCC_RST_MAX_ANGLE,
    `SCC_RST_MAX_SLIP, `SCC_RST_MAKE_DELAY};
  scc_row_t rows [16] = '{
    '{8'h64, 8'h64, 16'h3e8, 8'h05, 8'h0a, 1'b0, 8'h00, 8'h01, 1'b1},
    '{8'h64, 8'h64, 16'h9c4, 8'h05, 8'h0a, 1'b0, 8'h00, 8'h01, 1'b0},
    '{8'h64, 8'h64, 16'h3e8, 8'h0a, 8'h0a, 1'b0, 8'h00, 8'h01, 1'b0},
    '{8'h64, 8'h64, 16'h3e8, 8'h09, 8'h0a, 1'b0, 8'h00, 8'h01, 1'b1},
    '{8'h64, 8'h64, 16'h3e8, 8'h05, 8'h3c, 1'b1, 8'h00, 8'h01, 1'b0},
    '{8'h64, 8'h64, 16'h3e8, 8'h05, 8'h28, 1'b1, 8'h64, 8'h01, 1'b1},
    '{8'h64, 8'h64, 16'h3e8, 8'h05, 8'h28, 1'b1, 8'h65, 8'h01, 1'b0},
    '{8'h64, 8'h64, 16'h3e8, 8'h05, 8'h28, 1'b0, 8'h32, 8'h01, 1'b0},
    '{8'h64, 8'h64, 16'h3e8, 8'h05, 8'h19, 1'b0, 8'h32, 8'h01, 1'b0},
    '{8'h64, 8'h64, 16'h3e8, 8'h05, 8'h14, 1'b0, 8'h00, 8'h01, 1'b1},
    '{8'h32, 8'h0a, 16'h3e8, 8'h32, 8'h0a, 1'b0, 8'h00, 8'h05, 1'b1},
    '{8'h31, 8'h0a, 16'h3e8, 8'h32, 8'h0a, 1'b0, 8'h00, 8'h05, 1'b0},
    '{8'h0a, 8'h32, 16'h3e8, 8'h32, 8'h0a, 1'b0, 8'h00, 8'h07, 1'b1},
    '{8'h0a, 8'h31, 16'h3e8, 8'h32, 8'h0a, 1'b0, 8'h00, 8'h07, 1'b0},
    '{8'h0b, 8'h32, 16'h3e8, 8'h32, 8'h0a, 1'b0, 8'h00, 8'h07, 1'b0},
    '{8'h0a, 8'h0b, 16'h3e8, 8'h32, 8'h0a, 1'b0, 8'h00, 8'h03, 1'b0}};
  always #10 ref_clk = ~ref_clk;
  scc_close_permit #(.PASS_DIV(8)) i_scc_close_permit (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_side_voltage(lsv),
    .bus_side_voltage(bsv), .line_volts_abs(lva), .bus_volts_abs(bva),
    .angle_diff_deg(ang), .slip_mhz(slp), .angle_closing(clo),
    .time_to_phase_ms(ttp), .contact_in(contact_in), .virtual_in(virtual_in),
    .remote_in(remote_in), .logic_elem(logic_elem), .block_in(block_in),
    .close_permit(close_permit), .output_relays(output_relays));
  scc_front_end_model i_scc_front_end_model (.line_side_voltage(lsv),
    .bus_side_voltage(bsv), .line_volts_abs(lva), .bus_volts_abs(bva),
    .angle_diff_deg(ang), .slip_mhz(slp), .angle_closing(clo),
    .time_to_phase_ms(ttp));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // two full passes plus input synchroniser delay
  task automatic apply(input logic [15:0] ctrl, input logic [7:0] lv, bv,
                       input logic [15:0] la, input logic [7:0] an, sl,
                       input logic cl, input logic [7:0] tp);
    wr(4'h0, ctrl);
    i_scc_front_end_model.set({8'h0, lv}, {8'h0, bv}, la, {8'h0, an},
                              {8'h0, sl}, cl, {8'h0, tp});
    repeat (20) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_pmt(input logic ex);
    `CHK("close_permit", ex, close_permit)
    `CHK("output_relays", {6{ex}}, output_relays)
  endtask
  function automatic logic ds_exp(input logic [2:0] ds, input logic ll, bl);
    case (ds)
      `SCC_DS_BOTH_DEAD_PERMIT: return !ll && !bl;
      `SCC_DS_LIVE_LINE_DEAD_BUS_PERMIT: return ll && !bl;
      `SCC_DS_DEAD_LINE_LIVE_BUS_PERMIT: return !ll && bl;
      `SCC_DS_ANY_LINE_DEAD_BUS_PERMIT: return !bl;
      `SCC_DS_DEAD_LINE_ANY_BUS_PERMIT: return !ll;
      `SCC_DS_ONE_SIDE_DEAD_PERMIT: return ll ^ bl;
      `SCC_DS_NBL:   return !(ll && bl);
      default:       return 1'b0;
    endcase
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    print_verdict();
  end
  initial begin
    logic [15:0] d;
    int codes [8] = '{2, 11, 12, 43, 44, 75, 76, 91};
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk_pmt(1'b0);
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], d);
      `CHK("reg_default", dflt[a], d)
    end
    foreach (rows[i]) begin
      apply({8'h0, rows[i].ctrl}, rows[i].lv, rows[i].bv, rows[i].la,
            rows[i].ang, rows[i].slip, rows[i].clo, rows[i].ttp);
      chk_pmt(rows[i].ex);
    end
    // 5 is dead and 0x64 live on both sides; angle 0x32 kills sync
    for (int ds = 0; ds < 8; ds++) for (int c = 0; c < 4; c++) begin
      apply({12'h0, ds[2:0], 1'b1}, c[0] ? 8'h64 : 8'h05, c[1] ? 8'h64 : 8'h05,
            16'h3e8, 8'h32, 8'h0a, 1'b0, 8'h00);
      chk_pmt(ds_exp(ds[2:0], c[0], c[1]));
    end
    apply(16'h0001, 8'h64, 8'h64, 16'h3e8, 8'h05, 8'h0a, 1'b0, 8'h00);
    @(posedge ref_clk);
    block_in <= 1'b1;
    apply(16'h0001, 8'h64, 8'h64, 16'h3e8, 8'h05, 8'h0a, 1'b0, 8'h00);
    chk_pmt(1'b0);
    apply(16'h0011, 8'h64, 8'h64, 16'h3e8, 8'h05, 8'h0a, 1'b0, 8'h00);
    chk_pmt(1'b1);
    @(posedge ref_clk);
    block_in <= 1'b0;
    foreach (codes[k]) for (int inv = 0; inv < 2; inv++) begin
      @(posedge ref_clk);
      {logic_elem, remote_in, virtual_in, contact_in} <=
        inv ? ~(90'h1 << (codes[k] - 2)) : 90'h1 << (codes[k] - 2);
      apply({5'h0, codes[k][6:0], 4'h1}, 8'h64, 8'h64, 16'h3e8, 8'h32,
            8'h0a, 1'b0, 8'h00);
      chk_pmt(inv == 0);
    end
    apply(16'h0002, 8'h05, 8'h05, 16'h3e8, 8'h05, 8'h0a, 1'b0, 8'h00);
    chk_pmt(1'b0);
    wr(4'h9, 16'hffff);
    rd(4'h9, d);
    `CHK("status_unused", 7'h00, d[15:9])
    `CHK("status_word", 16'h004a, d)
    rd(4'hf, d);
    `CHK("unmapped_read", 16'h0000, d)
    wr(4'h6, 16'h0014);
    rd(4'h6, d);
    `CHK("max_angle_rw", 16'h0014, d)
    apply(16'h0003, 8'h05, 8'h05, 16'h3e8, 8'h05, 8'h0a, 1'b0, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk_pmt(1'b0);
    rd(4'h0, d);
    `CHK("ctrl_after_reset", `SCC_RST_CTRL, d)
    print_verdict();
  end
endmodule // scc_close_permit_bench
